// ===== src/uslb_map.vh
// Purpose: offsets, field positions, reset values and timing counts of the serial unit
// Assumes: included by every design file of the block
// Notes: offsets are relative to the unit's base port
`ifndef USLB_MAP_VH
`define USLB_MAP_VH
// port offsets
`define USLB_OFS_DATA 3'h0
`define USLB_OFS_IEN 3'h1
`define USLB_OFS_IID 3'h2
`define USLB_OFS_LCTL 3'h3
`define USLB_OFS_MCTL 3'h4
`define USLB_OFS_LSTAT 3'h5
`define USLB_OFS_MSTAT 3'h6
`define USLB_OFS_SPARE 3'h7
// line control fields
`define USLB_LC_WLEN 0
`define USLB_LC_STOP 2
`define USLB_LC_PEN 3
`define USLB_LC_EVEN 4
`define USLB_LC_STICK 5
`define USLB_LC_BRK 6
`define USLB_LC_DLAB 7
// modem control fields
`define USLB_MC_DTR 0
`define USLB_MC_RTS 1
`define USLB_MC_AUX1 2
`define USLB_MC_AUX2 3
`define USLB_MC_LOOP 4
// line status fields
`define USLB_LS_DR 0
`define USLB_LS_THRE 5
`define USLB_LS_TEMT 6
// interrupt enable fields
`define USLB_IE_RX 0
`define USLB_IE_TX 1
`define USLB_IE_LINE 2
`define USLB_IE_MDM 3
// interrupt ids, highest priority first
`define USLB_ID_LINE 2'h3
`define USLB_ID_RX 2'h2
`define USLB_ID_TX 2'h1
`define USLB_ID_MDM 2'h0
// reset values
`define USLB_RST_LCTL 8'h00
`define USLB_RST_MCTL 5'h00
`define USLB_RST_IEN 4'h0
`define USLB_RST_DIV 16'h0000
// timing
`define USLB_REF_CLK_HZ 1843200
`define USLB_OVERSAMPLE 5'd16
`define USLB_HALF_BIT 4'd7
`define USLB_LAST_TICK 4'hf
`define USLB_STOP_ONE 5'd15
`define USLB_STOP_HALF 5'd23
`define USLB_STOP_TWO 5'd31
`endif

// ===== src/uslb_baud.v
// Purpose: baud generator, divides the reference clock by the divisor latch
// Assumes: reference clock well below half the system clock
// Notes: tick is one system cycle wide, sixteen ticks per serial bit; divisor 0 halts it
`timescale 1ns/100ps
`include "uslb_map.vh"
module uslb_baud #(
	parameter DIV_W = 16
) (
	input wire clock,
	input wire reset,
	input wire ref_clk_in,
	input wire [DIV_W-1:0] divisor,
	output reg tick
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	reg [DIV_W-1:0] cnt_q;
	wire ref_edge;

	assign ref_edge = s2_q & ~s3_q;

	always @(posedge clock) begin
		if (reset) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			cnt_q <= {DIV_W{1'b0}};
			tick <= 1'b0;
		end else begin
			s1_q <= ref_clk_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			tick <= 1'b0;
			if (ref_edge && divisor != {DIV_W{1'b0}}) begin
				// one tick per divisor reference periods
				if (cnt_q >= divisor - {{(DIV_W-1){1'b0}}, 1'b1}) begin
					cnt_q <= {DIV_W{1'b0}};
					tick <= 1'b1;
				end else begin
					cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // uslb_baud

// ===== src/uslb_rx.v
// Purpose: receive shift register, assembles one character per frame
// Assumes: rx_line already synchronous, tick at sixteen per bit
// Notes: strobe is a one-cycle pulse carrying data and the three error flags
`timescale 1ns/100ps
`include "uslb_map.vh"
module uslb_rx (
	input wire clock,
	input wire reset,
	input wire tick,
	input wire rx_line,
	input wire [1:0] word_len,
	input wire parity_en,
	input wire parity_even,
	input wire parity_stick,
	output reg strobe,
	output reg [7:0] data,
	output reg perr,
	output reg ferr,
	output reg brk
);
	localparam S_IDLE = 6'h01;
	localparam S_START = 6'h02;
	localparam S_DATA = 6'h04;
	localparam S_PAR = 6'h08;
	localparam S_STOP = 6'h10;
	localparam S_HOLD = 6'h20;
	reg [5:0] st_q;
	reg [3:0] cnt_q;
	reg [2:0] bit_q;
	reg [7:0] sh_q;
	reg par_q;
	reg zero_q;
	reg perr_q;
	wire [2:0] last_bit;
	wire exp_par;

	assign last_bit = {1'b1, word_len};
	assign exp_par = parity_stick ? ~parity_even : (parity_even ? par_q : ~par_q);

	always @(posedge clock) begin
		if (reset) begin
			st_q <= S_IDLE;
			cnt_q <= 4'h0;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			par_q <= 1'b0;
			zero_q <= 1'b0;
			perr_q <= 1'b0;
			strobe <= 1'b0;
			data <= 8'h00;
			perr <= 1'b0;
			ferr <= 1'b0;
			brk <= 1'b0;
		end else begin
			strobe <= 1'b0;
			case (st_q)
			S_IDLE: begin
				if (tick && !rx_line) begin
					st_q <= S_START;
					cnt_q <= 4'h0;
				end
			end
			S_START: begin
				if (tick) begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == `USLB_HALF_BIT) begin
						cnt_q <= 4'h0;
						bit_q <= 3'h0;
						par_q <= 1'b0;
						zero_q <= 1'b1;
						perr_q <= 1'b0;
						st_q <= rx_line ? S_IDLE : S_DATA;
					end
				end
			end
			S_DATA: begin
				if (tick) begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == `USLB_LAST_TICK) begin
						sh_q <= {rx_line, sh_q[7:1]};
						par_q <= par_q ^ rx_line;
						zero_q <= zero_q & ~rx_line;
						bit_q <= bit_q + 3'h1;
						if (bit_q == last_bit) begin
							st_q <= parity_en ? S_PAR : S_STOP;
						end
					end
				end
			end
			S_PAR: begin
				if (tick) begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == `USLB_LAST_TICK) begin
						perr_q <= rx_line != exp_par;
						zero_q <= zero_q & ~rx_line;
						st_q <= S_STOP;
					end
				end
			end
			S_STOP: begin
				if (tick) begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == `USLB_LAST_TICK) begin
						strobe <= 1'b1;
						data <= sh_q >> (3'h7 - last_bit);
						perr <= perr_q;
						ferr <= ~rx_line;
						brk <= zero_q & ~rx_line;
						st_q <= rx_line ? S_IDLE : S_HOLD;
					end
				end
			end
			S_HOLD: begin
				// a held-low line starts no new frame until it returns to mark
				if (rx_line) begin
					st_q <= S_IDLE;
				end
			end
			default: begin
				st_q <= S_IDLE;
			end
			endcase
		end
	end
endmodule // uslb_rx

// ===== src/uslb_top.v
// Purpose: serial transceiver with line and modem status, loopback and baud divisor
// Assumes: io_rd and io_wr are one-cycle strobes on clock; read data follow one cycle later
// Notes: modem and serial pins are active low where the name ends in _n
`timescale 1ns/100ps
`include "uslb_map.vh"
module uslb_top (
	input wire clock,
	input wire reset,
	input wire ref_clk_in,
	input wire [2:0] io_addr,
	input wire [7:0] io_wr_data,
	input wire io_wr,
	input wire io_rd,
	output wire [7:0] io_rd_data,
	output wire intr,
	input wire serial_rx_line,
	output wire serial_tx_line,
	input wire cts_n,
	input wire dsr_n,
	input wire ri_n,
	input wire rlsd_n,
	output wire dtr_n,
	output wire rts_n,
	output wire aux_output_one_n,
	output wire aux_output_two_n
);
	localparam T_IDLE = 5'h01;
	localparam T_START = 5'h02;
	localparam T_DATA = 5'h04;
	localparam T_PAR = 5'h08;
	localparam T_STOP = 5'h10;

	reg [7:0] lctl_q;
	reg [4:0] mctl_q;
	reg [3:0] ien_q;
	reg [15:0] div_q;
	reg [7:0] rbuf_q;
	reg dr_q;
	reg [3:0] err_q;
	reg [3:0] mdelta_q;
	reg [3:0] mlev_q;
	reg [3:0] ms1_q;
	reg [3:0] ms2_q;
	reg rx_s1_q;
	reg rx_s2_q;
	reg [7:0] thr_q;
	reg thr_full_q;
	reg thre_int_q;
	reg [7:0] tsr_q;
	reg [4:0] tst_q;
	reg [4:0] tcnt_q;
	reg [2:0] tbit_q;
	reg tpar_q;
	reg tout_q;
	reg [7:0] rd_data_q;
	reg intr_q;
	reg tx_pin_q;
	reg [3:0] mout_n_q;

	wire tick;
	wire rx_strobe;
	wire [7:0] rx_data;
	wire rx_perr;
	wire rx_ferr;
	wire rx_brk;
	wire loop_on;
	wire dlab;
	wire tx_line;
	wire rx_in;
	wire [3:0] loop_lev;
	wire [3:0] mlev;
	wire [3:0] mchg;
	wire [3:0] err_set;
	wire wr_data;
	wire wr_lstat;
	wire wr_mstat;
	wire rd_rbuf;
	wire rd_lstat;
	wire rd_mstat;
	wire rd_iid;
	wire tx_load;
	wire [2:0] tx_last;
	wire [4:0] stop_last;
	wire p_line;
	wire p_rx;
	wire p_tx;
	wire p_mdm;
	wire [1:0] iid;
	wire [7:0] lstat;
	wire [7:0] mstat;
	reg [7:0] rd_mux;

	assign loop_on = mctl_q[`USLB_MC_LOOP];
	assign dlab = lctl_q[`USLB_LC_DLAB];
	assign tx_line = lctl_q[`USLB_LC_BRK] ? 1'b0 : tout_q;
	assign rx_in = loop_on ? tx_line : rx_s2_q;
	// internal modem levels in status order: cts, dsr, ri, rlsd
	assign loop_lev = {mctl_q[`USLB_MC_AUX2], mctl_q[`USLB_MC_AUX1], mctl_q[`USLB_MC_DTR], mctl_q[`USLB_MC_RTS]};
	assign mlev = loop_on ? loop_lev : ~ms2_q;
	assign mchg[0] = mlev[0] ^ mlev_q[0];
	assign mchg[1] = mlev[1] ^ mlev_q[1];
	assign mchg[2] = mlev_q[2] & ~mlev[2];
	assign mchg[3] = mlev[3] ^ mlev_q[3];
	assign err_set = {rx_brk, rx_ferr, rx_perr, dr_q & ~rd_rbuf} & {4{rx_strobe}};

	assign wr_data = io_wr && io_addr == `USLB_OFS_DATA && !dlab;
	assign wr_lstat = io_wr && io_addr == `USLB_OFS_LSTAT;
	assign wr_mstat = io_wr && io_addr == `USLB_OFS_MSTAT;
	assign rd_rbuf = io_rd && io_addr == `USLB_OFS_DATA && !dlab;
	assign rd_lstat = io_rd && io_addr == `USLB_OFS_LSTAT;
	assign rd_mstat = io_rd && io_addr == `USLB_OFS_MSTAT;
	assign rd_iid = io_rd && io_addr == `USLB_OFS_IID;

	assign lstat = {1'b0, tst_q == T_IDLE, ~thr_full_q, err_q, dr_q};
	assign mstat = {mlev, mdelta_q};

	// pending sources, all gated by the enable register
	assign p_line = ien_q[`USLB_IE_LINE] & (|err_q);
	assign p_rx = ien_q[`USLB_IE_RX] & dr_q;
	assign p_tx = ien_q[`USLB_IE_TX] & thre_int_q;
	assign p_mdm = ien_q[`USLB_IE_MDM] & (|mdelta_q);
	assign iid = p_line ? `USLB_ID_LINE : p_rx ? `USLB_ID_RX : p_tx ? `USLB_ID_TX : `USLB_ID_MDM;

	assign tx_load = thr_full_q && (tst_q == T_IDLE || (tst_q == T_STOP && tick && tcnt_q == stop_last));
	assign tx_last = {1'b1, lctl_q[1:0]};
	assign stop_last = !lctl_q[`USLB_LC_STOP] ? `USLB_STOP_ONE :
		(lctl_q[1:0] == 2'b00 ? `USLB_STOP_HALF : `USLB_STOP_TWO);

	assign io_rd_data = rd_data_q;
	assign intr = intr_q;
	assign serial_tx_line = tx_pin_q;
	assign dtr_n = mout_n_q[0];
	assign rts_n = mout_n_q[1];
	assign aux_output_one_n = mout_n_q[2];
	assign aux_output_two_n = mout_n_q[3];

	uslb_baud #(
		.DIV_W(16)
	) u_baud (
		.clock(clock),
		.reset(reset),
		.ref_clk_in(ref_clk_in),
		.divisor(div_q),
		.tick(tick)
	);

	uslb_rx u_rx (
		.clock(clock),
		.reset(reset),
		.tick(tick),
		.rx_line(rx_in),
		.word_len(lctl_q[1:0]),
		.parity_en(lctl_q[`USLB_LC_PEN]),
		.parity_even(lctl_q[`USLB_LC_EVEN]),
		.parity_stick(lctl_q[`USLB_LC_STICK]),
		.strobe(rx_strobe),
		.data(rx_data),
		.perr(rx_perr),
		.ferr(rx_ferr),
		.brk(rx_brk)
	);

	always @* begin
		case (io_addr)
		`USLB_OFS_DATA: rd_mux = dlab ? div_q[7:0] : rbuf_q;
		`USLB_OFS_IEN: rd_mux = dlab ? div_q[15:8] : {4'h0, ien_q};
		`USLB_OFS_IID: rd_mux = {5'h00, iid, ~(p_line | p_rx | p_tx | p_mdm)};
		`USLB_OFS_LCTL: rd_mux = lctl_q;
		`USLB_OFS_MCTL: rd_mux = {3'h0, mctl_q};
		`USLB_OFS_LSTAT: rd_mux = lstat;
		`USLB_OFS_MSTAT: rd_mux = mstat;
		default: rd_mux = 8'h00;
		endcase
	end

	// pins, status and control registers
	always @(posedge clock) begin
		if (reset) begin
			lctl_q <= `USLB_RST_LCTL;
			mctl_q <= `USLB_RST_MCTL;
			ien_q <= `USLB_RST_IEN;
			div_q <= `USLB_RST_DIV;
			rbuf_q <= 8'h00;
			dr_q <= 1'b0;
			mlev_q <= 4'h0;
			ms1_q <= 4'hf;
			ms2_q <= 4'hf;
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rd_data_q <= 8'h00;
			intr_q <= 1'b0;
			tx_pin_q <= 1'b1;
			mout_n_q <= 4'hf;
		end else begin
			ms1_q <= {rlsd_n, ri_n, dsr_n, cts_n};
			ms2_q <= ms1_q;
			rx_s1_q <= serial_rx_line;
			rx_s2_q <= rx_s1_q;
			mlev_q <= mlev;
			tx_pin_q <= loop_on ? 1'b1 : tx_line;
			mout_n_q <= ~mctl_q[3:0];
			intr_q <= p_line | p_rx | p_tx | p_mdm;
			if (io_rd) begin
				rd_data_q <= rd_mux;
			end
			if (io_wr) begin
				case (io_addr)
				`USLB_OFS_DATA: if (dlab) div_q[7:0] <= io_wr_data;
				`USLB_OFS_IEN: begin
					if (dlab) begin
						div_q[15:8] <= io_wr_data;
					end else begin
						ien_q <= io_wr_data[3:0];
					end
				end
				`USLB_OFS_LCTL: lctl_q <= io_wr_data;
				`USLB_OFS_MCTL: mctl_q <= io_wr_data[4:0];
				default: ;
				endcase
			end
			if (rx_strobe) begin
				rbuf_q <= rx_data;
			end
			// data ready: clear, then test write, then hardware set wins
			if (rd_rbuf) begin
				dr_q <= 1'b0;
			end
			if (wr_lstat) begin
				dr_q <= io_wr_data[`USLB_LS_DR];
			end
			if (rx_strobe) begin
				dr_q <= 1'b1;
			end
		end
	end

	// error and delta flags: set beats clear in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
			always @(posedge clock) begin
				if (reset) begin
					err_q[gi] <= 1'b0;
					mdelta_q[gi] <= 1'b0;
				end else begin
					if (err_set[gi]) begin
						err_q[gi] <= 1'b1;
					end else if (wr_lstat) begin
						err_q[gi] <= io_wr_data[gi + 1];
					end else if (rd_lstat) begin
						err_q[gi] <= 1'b0;
					end
					if (mchg[gi]) begin
						mdelta_q[gi] <= 1'b1;
					end else if (wr_mstat) begin
						mdelta_q[gi] <= io_wr_data[gi];
					end else if (rd_mstat) begin
						mdelta_q[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// transmitter: holding register feeds the shift register
	always @(posedge clock) begin
		if (reset) begin
			thr_q <= 8'h00;
			thr_full_q <= 1'b0;
			thre_int_q <= 1'b0;
			tsr_q <= 8'h00;
			tst_q <= T_IDLE;
			tcnt_q <= 5'h00;
			tbit_q <= 3'h0;
			tpar_q <= 1'b0;
			tout_q <= 1'b1;
		end else begin
			if (tick) begin
				tcnt_q <= tcnt_q + 5'h01;
			end
			case (tst_q)
			T_IDLE: tout_q <= 1'b1;
			T_START: begin
				if (tick && tcnt_q[3:0] == `USLB_LAST_TICK) begin
					tst_q <= T_DATA;
					tcnt_q <= 5'h00;
					tout_q <= tsr_q[0];
					tpar_q <= tsr_q[0];
					tsr_q <= {1'b0, tsr_q[7:1]};
					tbit_q <= 3'h0;
				end
			end
			T_DATA: begin
				if (tick && tcnt_q[3:0] == `USLB_LAST_TICK) begin
					tcnt_q <= 5'h00;
					tbit_q <= tbit_q + 3'h1;
					if (tbit_q == tx_last) begin
						if (lctl_q[`USLB_LC_PEN]) begin
							tst_q <= T_PAR;
							tout_q <= lctl_q[`USLB_LC_STICK] ? ~lctl_q[`USLB_LC_EVEN] :
								(lctl_q[`USLB_LC_EVEN] ? tpar_q : ~tpar_q);
						end else begin
							tst_q <= T_STOP;
							tout_q <= 1'b1;
						end
					end else begin
						tout_q <= tsr_q[0];
						tpar_q <= tpar_q ^ tsr_q[0];
						tsr_q <= {1'b0, tsr_q[7:1]};
					end
				end
			end
			T_PAR: begin
				if (tick && tcnt_q[3:0] == `USLB_LAST_TICK) begin
					tst_q <= T_STOP;
					tcnt_q <= 5'h00;
					tout_q <= 1'b1;
				end
			end
			T_STOP: begin
				if (tick && tcnt_q == stop_last) begin
					tst_q <= T_IDLE;
					tcnt_q <= 5'h00;
				end
			end
			default: tst_q <= T_IDLE;
			endcase
			if (tx_load) begin
				tsr_q <= thr_q;
				thr_full_q <= 1'b0;
				tst_q <= T_START;
				tcnt_q <= 5'h00;
				tout_q <= 1'b0;
			end
			if (wr_lstat) begin
				thr_full_q <= ~io_wr_data[`USLB_LS_THRE];
			end
			if (wr_data) begin
				thr_q <= io_wr_data;
				thr_full_q <= 1'b1;
			end
			if (tx_load || (wr_lstat && io_wr_data[`USLB_LS_THRE])) begin
				thre_int_q <= 1'b1;
			end else if (wr_data || (rd_iid && iid == `USLB_ID_TX)) begin
				thre_int_q <= 1'b0;
			end
		end
	end
endmodule // uslb_top

// ===== bench/uslb_checker.sv
// Purpose: port-level assertions for the serial unit
// Assumes: one clock domain, synchronous active-high reset
// Notes: control writes are shadowed here to know the mode
`timescale 1ns/100ps
module uslb_checker (
	input wire clock,
	input wire reset,
	input wire [2:0] io_addr,
	input wire [7:0] io_wr_data,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_rd_data,
	input wire intr,
	input wire serial_tx_line,
	input wire cts_n,
	input wire dsr_n,
	input wire ri_n,
	input wire rlsd_n
);
	reg [4:0] mcr_q;
	reg [3:0] ier_q;
	reg dlab_q;
	reg [2:0] age_q;
	reg [2:0] pin_age_q;
	reg [3:0] pins_q;
	wire [3:0] pins = {rlsd_n, ri_n, dsr_n, cts_n};
	wire quiet = age_q > 3'd3 && pin_age_q > 3'd3;
	always @(posedge clock) begin
		pins_q <= pins;
		if (reset) begin
			mcr_q <= 5'h00;
			ier_q <= 4'h0;
			dlab_q <= 1'b0;
			age_q <= 3'h7;
			pin_age_q <= 3'h0;
		end else begin
			if (age_q != 3'h7)
				age_q <= age_q + 3'h1;
			if (pin_age_q != 3'h7)
				pin_age_q <= pin_age_q + 3'h1;
			if (pins != pins_q)
				pin_age_q <= 3'h0;
			if (io_wr && (io_addr == 3'h1 || io_addr == 3'h3 || io_addr == 3'h4))
				age_q <= 3'h0;
			if (io_wr && io_addr == 3'h4)
				mcr_q <= io_wr_data[4:0];
			if (io_wr && io_addr == 3'h3)
				dlab_q <= io_wr_data[7];
			if (io_wr && io_addr == 3'h1 && !dlab_q)
				ier_q <= io_wr_data[3:0];
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	sequence msr_rd;
		io_rd && io_addr == 3'h6 && quiet;
	endsequence
	sequence lsr_rd;
		io_rd && io_addr == 3'h5;
	endsequence
	loop_tx_mark_a: assert property (mcr_q[4] && age_q > 3'd1 |-> serial_tx_line)
		else $error("tx pin not marking in loopback");
	msr_level_a: assert property (msr_rd ##0 !mcr_q[4] |=> io_rd_data[7:4] == ~$past(pins))
		else $error("modem levels wrong");
	msr_loop_a: assert property (msr_rd ##0 mcr_q[4] |=> io_rd_data[7:4] == {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]})
		else $error("loopback modem levels wrong");
	msr_clear_a: assert property (msr_rd ##2 msr_rd |=> io_rd_data[3:0] == 4'h0)
		else $error("modem deltas not cleared by read");
	lsr_clear_a: assert property (lsr_rd ##2 lsr_rd |=> io_rd_data[4:1] == 4'h0)
		else $error("line errors not cleared by read");
	mdm_intr_a: assert property (msr_rd ##1 (io_rd_data[3:0] != 4'h0 && ier_q[3]) |-> intr)
		else $error("modem interrupt missing");
	lsr_test_a: assert property (io_wr && io_addr == 3'h5 && io_wr_data[4:1] != 4'h0 && ier_q[2] |-> ##[1:3] intr)
		else $error("line test interrupt missing");
	msr_test_a: assert property (io_wr && io_addr == 3'h6 && io_wr_data[3:0] != 4'h0 && ier_q[3] |-> ##[1:3] intr)
		else $error("modem test interrupt missing");
	ier_gate_a: assert property (ier_q == 4'h0 && age_q > 3'd2 |-> !intr)
		else $error("interrupt with all sources disabled");
endmodule // uslb_checker

bind uslb_top uslb_checker i_chk (.clock(clock), .reset(reset), .io_addr(io_addr), .io_wr_data(io_wr_data),
	.io_wr(io_wr), .io_rd(io_rd), .io_rd_data(io_rd_data), .intr(intr), .serial_tx_line(serial_tx_line),
	.cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .rlsd_n(rlsd_n));

// ===== bench/uslb_modem.sv
// Purpose: far-side modem and terminal for the serial unit bench
// Assumes: divisor 1, so one bit is sixteen reference periods
// Notes: its receiver logs 8-bit frames seen on the tx pin
`timescale 1ns/100ps
module uslb_modem #(
	parameter real BIT_NS = 8681.6
) (
	input wire serial_tx_line,
	output reg serial_rx_line,
	output wire cts_n,
	output wire dsr_n,
	output wire ri_n,
	output wire rlsd_n
);
	reg [3:0] lines_n = 4'hf;
	reg [7:0] rx_log [0:7];
	integer rx_cnt = 0;
	integer i;
	assign {rlsd_n, ri_n, dsr_n, cts_n} = lines_n;
	initial serial_rx_line = 1'b1;
	// start bit, n bits lsb first, then one marking bit
	task send(input [12:0] bits, input integer n);
		integer k;
		begin
			serial_rx_line = 1'b0;
			#(BIT_NS);
			for (k = 0; k < n; k = k + 1) begin
				serial_rx_line = bits[k];
				#(BIT_NS);
			end
			serial_rx_line = 1'b1;
			#(BIT_NS);
		end
	endtask
	always begin
		@(negedge serial_tx_line);
		#(BIT_NS / 2);
		for (i = 0; i < 8; i = i + 1) begin
			#(BIT_NS);
			rx_log[rx_cnt % 8][i] = serial_tx_line;
		end
		#(BIT_NS);
		rx_cnt = rx_cnt + 1;
	end
endmodule // uslb_modem

// ===== bench/testbench.sv
// Purpose: self-checking bench for status, modem, loopback and divisor of the serial unit
// Assumes: 1.8432 MHz reference, divisor 1
// Notes: strobes are driven from the falling edge
`timescale 1ns/100ps
module testbench;
	reg clock = 1'b0;
	reg reset = 1'b1;
	reg ref_clk_in = 1'b0;
	reg [2:0] io_addr = 3'h0;
	reg [7:0] io_wr_data = 8'h00;
	reg io_wr = 1'b0;
	reg io_rd = 1'b0;
	wire [7:0] io_rd_data;
	wire intr, serial_rx_line, serial_tx_line, cts_n, dsr_n, ri_n, rlsd_n;
	wire dtr_n, rts_n, aux_output_one_n, aux_output_two_n;
	integer bad_count = 0;
	integer n_tests = 0;
	integer cycles = 0;
	reg [7:0] v;
	initial forever #25 clock = ~clock;
	initial forever #271.3 ref_clk_in = ~ref_clk_in;
	uslb_top i_dut (.clock(clock), .reset(reset), .ref_clk_in(ref_clk_in), .io_addr(io_addr),
		.io_wr_data(io_wr_data), .io_wr(io_wr), .io_rd(io_rd), .io_rd_data(io_rd_data), .intr(intr),
		.serial_rx_line(serial_rx_line), .serial_tx_line(serial_tx_line), .cts_n(cts_n), .dsr_n(dsr_n),
		.ri_n(ri_n), .rlsd_n(rlsd_n), .dtr_n(dtr_n), .rts_n(rts_n), .aux_output_one_n(aux_output_one_n),
		.aux_output_two_n(aux_output_two_n));
	uslb_modem i_modem (.serial_tx_line(serial_tx_line), .serial_rx_line(serial_rx_line), .cts_n(cts_n),
		.dsr_n(dsr_n), .ri_n(ri_n), .rlsd_n(rlsd_n));
	task report_and_stop;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, bad_count);
			if (bad_count == 0 && n_tests > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 60000) begin
			bad_count = bad_count + 1;
			report_and_stop;
		end
	end
	task wr(input [2:0] a, input [7:0] d);
		begin
			@(negedge clock);
			io_addr = a;
			io_wr_data = d;
			io_wr = 1'b1;
			@(negedge clock);
			io_wr = 1'b0;
		end
	endtask
	task rd(input [2:0] a);
		begin
			@(negedge clock);
			io_addr = a;
			io_rd = 1'b1;
			@(negedge clock);
			io_rd = 1'b0;
			v = io_rd_data;
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp, input string w);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("CHECK FAILED at %0t: %s got %h expected %h", $time, w, got, exp);
			end
		end
	endtask
	task rc(input [2:0] a, input [7:0] m, input [7:0] e, input string w);
		begin
			rd(a);
			chk(v & m, e, w);
		end
	endtask
	task ichk(input e);
		begin
			repeat (3) @(negedge clock);
			chk({7'h00, intr}, {7'h00, e}, "intr");
		end
	endtask
	task mdm(input [3:0] n, input [7:0] e);
		begin
			@(negedge clock);
			i_modem.lines_n = n;
			repeat (6) @(negedge clock);
			ichk(1'b1);
			rc(3'h6, 8'hff, e, "msr");
			rc(3'h6, 8'h0f, 8'h00, "msr reread");
			ichk(1'b0);
		end
	endtask
	task poll(input [2:0] a, input [7:0] m);
		integer k;
		begin
			k = 0;
			v = 8'h00;
			while (k < 4000 && (v & m) == 8'h00) begin
				rd(a);
				k = k + 1;
			end
		end
	endtask
	initial begin
		repeat (3) @(negedge clock);
		reset = 1'b0;
		rc(3'h5, 8'hff, 8'h60, "lsr reset");
		rc(3'h6, 8'h0f, 8'h00, "msr reset");
		wr(3'h3, 8'h83);
		wr(3'h0, 8'h00);
		wr(3'h1, 8'h09);
		rc(3'h1, 8'hff, 8'h09, "div hi");
		rc(3'h0, 8'hff, 8'h00, "div lo");
		wr(3'h0, 8'h01);
		wr(3'h1, 8'h00);
		wr(3'h3, 8'h03);
		$display("test setup done");
		wr(3'h1, 8'h08);
		mdm(4'hc, 8'h33);
		i_modem.lines_n = 4'h8;
		repeat (8) @(negedge clock);
		mdm(4'h4, 8'hbc);
		mdm(4'hd, 8'h29);
		mdm(4'hf, 8'h02);
		$display("test modem done");
		wr(3'h1, 8'h04);
		wr(3'h5, 8'h62);
		ichk(1'b1);
		rc(3'h5, 8'h1e, 8'h02, "lsr test");
		ichk(1'b0);
		wr(3'h1, 8'h08);
		wr(3'h6, 8'h04);
		ichk(1'b1);
		rc(3'h6, 8'h0f, 8'h04, "msr test");
		ichk(1'b0);
		wr(3'h1, 8'h00);
		wr(3'h5, 8'h62);
		ichk(1'b0);
		rd(3'h5);
		$display("test interrupt done");
		i_modem.send(13'h1a5, 9);
		rc(3'h5, 8'hff, 8'h61, "dr set");
		wr(3'h5, 8'h60);
		rc(3'h5, 8'hff, 8'h60, "dr zeroed");
		i_modem.send(13'h13c, 9);
		i_modem.send(13'h1c5, 9);
		rc(3'h5, 8'hff, 8'h63, "overrun");
		rc(3'h5, 8'hff, 8'h61, "overrun clear");
		rc(3'h0, 8'hff, 8'hc5, "rx data");
		rc(3'h5, 8'hff, 8'h60, "dr clear");
		i_modem.send(13'h055, 9);
		rc(3'h5, 8'h08, 8'h08, "framing");
		rd(3'h0);
		i_modem.send(13'h0000, 12);
		rc(3'h5, 8'h10, 8'h10, "break");
		rd(3'h0);
		wr(3'h3, 8'h1b);
		i_modem.send(13'h201, 10);
		rc(3'h5, 8'h04, 8'h04, "parity");
		rc(3'h5, 8'h04, 8'h00, "parity clear");
		rd(3'h0);
		wr(3'h3, 8'h03);
		$display("test receive done");
		wr(3'h0, 8'h96);
		rc(3'h5, 8'h60, 8'h20, "tx moved");
		wr(3'h0, 8'h5a);
		rc(3'h5, 8'h60, 8'h00, "tx full");
		poll(3'h5, 8'h40);
		chk(v & 8'h60, 8'h60, "tx idle");
		chk(i_modem.rx_log[0], 8'h96, "tx first");
		chk(i_modem.rx_log[1], 8'h5a, "tx second");
		$display("test transmit done");
		wr(3'h1, 8'h01);
		wr(3'h4, 8'h1d);
		i_modem.lines_n = 4'h0;
		repeat (8) @(negedge clock);
		rc(3'h6, 8'hf0, 8'he0, "loop msr");
		chk({4'h0, aux_output_two_n, aux_output_one_n, rts_n, dtr_n}, 8'h02, "modem outs");
		wr(3'h0, 8'hc3);
		poll(3'h5, 8'h01);
		ichk(1'b1);
		rc(3'h2, 8'hff, 8'h04, "iid rx");
		rc(3'h0, 8'hff, 8'hc3, "loop data");
		ichk(1'b0);
		wr(3'h3, 8'h43);
		repeat (2000) @(negedge clock);
		chk({7'h00, serial_tx_line}, 8'h01, "loop break pin");
		rc(3'h5, 8'h18, 8'h18, "loop break");
		wr(3'h3, 8'h03);
		chk(i_modem.rx_cnt[7:0], 8'h02, "tx pin quiet");
		$display("test loopback done");
		report_and_stop;
	end
endmodule // testbench
